// >>> verilog/ebha_pkg.sv
package ebha_pkg;
  localparam int ADDR_W_DEF = 16;
  localparam int SEG_W_DEF  = 7;
  localparam int DATA_W_DEF = 16;
  localparam int CS_W_DEF   = 5;
  localparam logic RST_SLAVE_MODE = 1'b0;
  typedef enum logic [1:0] {
    EBHA_RUN     = 2'b00,
    EBHA_DRAIN   = 2'b01,
    EBHA_HOLD    = 2'b11,
    EBHA_RELEASE = 2'b10
  } ebha_state_t;
endpackage

// >>> verilog/ebha_arbiter.sv
`timescale 1ns/1ps
module ebha_arbiter
  import ebha_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int SEG_W  = SEG_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int CS_W   = CS_W_DEF
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  // core side
  input  wire logic              arbitration_enable,
  input  wire logic              slave_mode_select,
  input  wire logic              open_drain_cs,
  input  wire logic              byte_split_writes,
  input  wire logic              ext_req,
  input  wire logic              ext_write,
  input  wire logic              ext_done,
  input  wire logic              per_req,
  input  wire logic              per_write,
  input  wire logic              per_ale,
  input  wire logic [ADDR_W-1:0] cyc_addr,
  input  wire logic [SEG_W-1:0]  cyc_seg,
  input  wire logic [DATA_W-1:0] cyc_wdata,
  input  wire logic              cyc_bhe_n,
  input  wire logic [CS_W-1:0]   cyc_cs_n,
  input  wire logic              shared_pin_direction,
  input  wire logic              shared_pin_data,
  output logic                   ext_stall,
  output logic                   in_hold,
  output logic                   internal_periph_select_n,
  // arbitration pins
  input  wire logic              hold_req_n,
  input  wire logic              hold_grant_n_in,
  output logic                   hold_grant_n_out,
  output logic                   hold_grant_n_oe,
  output logic                   bus_request_n,
  output logic                   bus_request_n_oe,
  // bus pins
  output logic [ADDR_W-1:0]      address_port,
  output logic                   address_port_oe,
  output logic [SEG_W-1:0]       seg_addr,
  output logic                   seg_addr_oe,
  output logic [DATA_W-1:0]      data_port_out,
  output logic                   data_port_oe,
  output logic                   ale,
  output logic                   ale_oe,
  output logic                   read_n,
  output logic                   write_low_byte_n,
  output logic                   write_high_byte_n,
  output logic                   byte_high_enable_n,
  output logic                   strobes_oe,
  output logic [CS_W-1:0]        cs_n,
  output logic                   cs_oe,
  output logic                   shared_pin_out,
  output logic                   shared_pin_oe
);

  // reset release
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // two-flop synchronisers for hold request and slave grant input
  logic hreq_s1_reg, hreq_s2_reg, hgnt_s1_reg, hgnt_s2_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreq_s1_reg <= 1'b1;
      hreq_s2_reg <= 1'b1;
      hgnt_s1_reg <= 1'b1;
      hgnt_s2_reg <= 1'b1;
    end else begin
      hreq_s1_reg <= hold_req_n;
      hreq_s2_reg <= hreq_s1_reg;
      hgnt_s1_reg <= hold_grant_n_in;
      hgnt_s2_reg <= hgnt_s1_reg;
    end
  end

  // sticky arbitration pin function, slave mode register resampled from slave_mode_select every cycle
  logic pins_armed_reg;
  logic slave_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins_armed_reg <= 1'b0;
      slave_reg      <= RST_SLAVE_MODE;
    end else begin
      pins_armed_reg <= pins_armed_reg | arbitration_enable;
      slave_reg      <= slave_mode_select;
    end
  end

  // hold is requested when the synced request is low; in slave mode
  // the partner grant low also means another master owns the bus
  wire hold_asked = ~hreq_s2_reg | (slave_reg & ~hgnt_s2_reg);
  wire cycle_busy = ext_req & ~ext_done;

  ebha_state_t state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EBHA_RUN:
        if (arbitration_enable && hold_asked)
          state_next = EBHA_DRAIN;
      EBHA_DRAIN:
        if (!cycle_busy)
          state_next = EBHA_HOLD;
      EBHA_HOLD:
        if (!hold_asked)
          state_next = EBHA_RELEASE;
      EBHA_RELEASE:
        state_next = EBHA_RUN;
      default:
        state_next = EBHA_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state_reg <= EBHA_RUN;
    else        state_reg <= state_next;
  end

  wire holding   = (state_reg == EBHA_HOLD);
  wire ext_cycle = ext_req & ~holding & (state_reg != EBHA_DRAIN | cycle_busy);
  wire per_cycle = per_req & ~ext_cycle;

  // last-address holders: update only on real cycles
  logic [ADDR_W-1:0] addr_reg;
  logic [SEG_W-1:0]  seg_reg;
  logic              bhe_reg;
  logic [CS_W-1:0]   cs_last_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg    <= '0;
      seg_reg     <= '0;
      bhe_reg     <= 1'b1;
      cs_last_reg <= '1;
    end else if (ext_cycle || per_cycle) begin
      addr_reg    <= cyc_addr;
      seg_reg     <= cyc_seg;
      bhe_reg     <= cyc_bhe_n;
      cs_last_reg <= per_cycle ? '1 : cyc_cs_n;
    end
  end

  // next pin values
  wire       drv_data = (ext_cycle & ext_write) | (per_cycle & per_write);
  wire       rd_next  = ~(ext_cycle & ~ext_write);
  wire       wr_act   = ext_cycle & ext_write;
  wire       wrl_next = ~wr_act;
  wire       wrh_next = byte_split_writes ? ~(wr_act & ~cyc_bhe_n) : 1'b1;
  wire       bhe_next = byte_split_writes ? wrh_next
                                          : ((ext_cycle | per_cycle) ? cyc_bhe_n : bhe_reg);
  wire       ale_next = per_cycle ? per_ale : ext_cycle;
  wire [CS_W-1:0] cs_next = ext_cycle ? cyc_cs_n : (per_cycle ? '1 : cs_last_reg);

  // registered pin drivers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      address_port       <= '0;
      address_port_oe    <= 1'b1;
      seg_addr           <= '0;
      seg_addr_oe        <= 1'b1;
      data_port_out      <= '0;
      data_port_oe       <= 1'b0;
      ale                <= 1'b0;
      ale_oe             <= 1'b1;
      read_n             <= 1'b1;
      write_low_byte_n   <= 1'b1;
      write_high_byte_n  <= 1'b1;
      byte_high_enable_n <= 1'b1;
      strobes_oe         <= 1'b1;
      cs_n               <= '1;
      cs_oe              <= 1'b1;
    end else if (holding) begin
      address_port_oe    <= 1'b0;
      seg_addr_oe        <= 1'b0;
      data_port_oe       <= 1'b0;
      ale                <= 1'b0;
      ale_oe             <= 1'b0;
      read_n             <= 1'b1;
      write_low_byte_n   <= 1'b1;
      write_high_byte_n  <= 1'b1;
      byte_high_enable_n <= 1'b1;
      strobes_oe         <= 1'b0;
      cs_n               <= '1;
      cs_oe              <= ~open_drain_cs;
    end else begin
      address_port       <= (ext_cycle | per_cycle) ? cyc_addr : addr_reg;
      address_port_oe    <= 1'b1;
      seg_addr           <= (ext_cycle | per_cycle) ? cyc_seg : seg_reg;
      seg_addr_oe        <= 1'b1;
      data_port_out      <= cyc_wdata;
      data_port_oe       <= drv_data;
      ale                <= ale_next;
      ale_oe             <= 1'b1;
      read_n             <= rd_next;
      write_low_byte_n   <= wrl_next;
      write_high_byte_n  <= wrh_next;
      byte_high_enable_n <= bhe_next;
      strobes_oe         <= 1'b1;
      cs_n               <= cs_next;
      cs_oe              <= 1'b1;
    end
  end

  // arbitration pin drivers and core handshakes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_grant_n_out         <= 1'b1;
      hold_grant_n_oe          <= 1'b0;
      bus_request_n            <= 1'b1;
      bus_request_n_oe         <= 1'b0;
      ext_stall                <= 1'b0;
      in_hold                  <= 1'b0;
      internal_periph_select_n <= 1'b1;
      shared_pin_out           <= 1'b0;
      shared_pin_oe            <= 1'b0;
    end else begin
      hold_grant_n_out         <= ~holding;
      hold_grant_n_oe          <= pins_armed_reg & ~slave_reg;
      bus_request_n            <= ~(holding & ext_req);
      bus_request_n_oe         <= pins_armed_reg;
      ext_stall                <= holding & ext_req;
      in_hold                  <= holding;
      internal_periph_select_n <= ~per_cycle;
      shared_pin_out           <= shared_pin_data;
      shared_pin_oe            <= holding & shared_pin_direction;
    end
  end

endmodule

// >>> dv/ebha_arbiter_sva.sv
`timescale 1ns/1ps
module ebha_arbiter_sva
  import ebha_pkg::*;
#(parameter int CS_W = CS_W_DEF) (
  input wire logic mclk, resetn, arbitration_enable, open_drain_cs, ext_req, per_req,
  input wire logic hold_req_n, hold_grant_n_out, ext_stall, in_hold, bus_request_n,
  input wire logic internal_periph_select_n, address_port_oe, data_port_oe, ale,
  input wire logic read_n, write_low_byte_n, cs_oe,
  input wire logic [CS_W-1:0] cs_n
);
  // single domain, all checks off while in reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // hold demand taken while enabled and no external cycle runs
  sequence s_take;
    arbitration_enable && !in_hold && !ext_req && $fell(hold_req_n)
    ##1 (!hold_req_n && arbitration_enable && !ext_req)[*3];
  endsequence
  // hold demand withdrawn and kept withdrawn
  sequence s_give;
    in_hold && $rose(hold_req_n) ##1 hold_req_n[*4];
  endsequence
  a_grant_on_req: assert property (s_take |-> ##[0:3] !hold_grant_n_out)
    else $error("grant missing");
  a_grant_off_rel: assert property (s_give |-> ##[0:2] hold_grant_n_out)
    else $error("grant not returned");
  a_hold_floats_bus: assert property (in_hold && $past(in_hold) |->
    !address_port_oe && !data_port_oe) else $error("bus driven in hold");
  a_cs_in_hold: assert property (in_hold && $past(in_hold) |->
    (open_drain_cs ? !cs_oe : cs_oe && &cs_n)) else $error("cs wrong");
  a_bus_request_n_only_hold: assert property (!bus_request_n |-> in_hold)
    else $error("bus request outside hold");
  a_stall_only_hold: assert property (ext_stall |-> in_hold)
    else $error("stall outside hold");
  a_hold_kept: assert property (in_hold && !hold_req_n && !$past(hold_req_n)
    && !$past(hold_req_n, 2) |=> in_hold) else $error("hold left early");
  a_per_select: assert property (per_req && !in_hold |=>
    !internal_periph_select_n && &cs_n) else $error("periph select wrong");
  a_idle_quiet: assert property ($past(!ext_req && !per_req && !in_hold) && !in_hold |->
    read_n && write_low_byte_n && !ale && !data_port_oe) else $error("idle pins");
endmodule
bind ebha_arbiter ebha_arbiter_sva #(.CS_W(CS_W)) u_sva (.*);

// >>> dv/ebha_master_model.sv
`timescale 1ns/1ps
module ebha_master_model (
  input  wire logic mclk,
  input  wire logic want,
  input  wire logic hold_grant_n,
  output logic      hold_req_n,
  output logic      owns
);
  // demand held low while wanted, raised to hand the bus back
  initial hold_req_n = 1'b1;
  always @(posedge mclk) hold_req_n <= #1 !want;
  // shared bus used only once the grant is seen low
  initial owns = 1'b0;
  always @(posedge mclk) owns <= #1 want && !hold_grant_n;
endmodule

// >>> dv/ebha_arbiter_tb.sv
`timescale 1ns/1ps
module ebha_arbiter_tb
  import ebha_pkg::*;
;
  typedef struct packed {
    logic ext, per, wr; logic [15:0] addr, wd; logic [4:0] cs;
    logic e_oe; logic [15:0] e_addr; logic [4:0] e_cs; logic e_sel;
  } ebha_row_t;
  logic mclk = 0, resetn = 0, arbitration_enable = 0, slave_mode_select = 0, open_drain_cs = 0;
  logic byte_split_writes = 0, ext_req = 0, ext_write = 0, ext_done = 0, per_req = 0;
  logic per_write = 0, per_ale = 0, cyc_bhe_n = 1, shared_pin_direction = 0;
  logic shared_pin_data = 0, want = 0, slv_grant_n = 1;
  logic [15:0] cyc_addr = 0, cyc_wdata = 0;
  logic [6:0] cyc_seg = 0;
  logic [4:0] cyc_cs_n = 5'h1f;
  wire logic hold_req_n, hold_grant_n_in, hold_grant_n_out, hold_grant_n_oe, bus_request_n, owns;
  wire logic bus_request_n_oe, ext_stall, in_hold, internal_periph_select_n, address_port_oe;
  wire logic seg_addr_oe, data_port_oe, ale, ale_oe, read_n, write_low_byte_n, write_high_byte_n;
  wire logic byte_high_enable_n, strobes_oe, cs_oe, shared_pin_out, shared_pin_oe;
  wire logic [15:0] address_port, data_port_out;
  wire logic [6:0] seg_addr;
  wire logic [4:0] cs_n;
  int error_cnt = 0, checks = 0;
  // cycle rows: ext, per, write, addr, wdata, cs in; data oe, address, cs, select out
  ebha_row_t rows [5] = '{
    '{0, 1, 1, 16'h1234, 16'habcd, 5'h1e, 1, 16'h1234, 5'h1f, 0},
    '{0, 1, 0, 16'h5678, 16'h0000, 5'h1e, 0, 16'h5678, 5'h1f, 0},
    '{0, 0, 0, 16'h9999, 16'h0000, 5'h1e, 0, 16'h5678, 5'h1f, 1},
    '{1, 0, 1, 16'h0042, 16'h0055, 5'h1e, 1, 16'h0042, 5'h1e, 1},
    '{0, 0, 0, 16'h7777, 16'h0000, 5'h1d, 0, 16'h0042, 5'h1e, 1}};
  // grant wire: design drives it in master mode once arbitration has been enabled, else the bench, idle pulled high
  assign hold_grant_n_in = hold_grant_n_oe ? hold_grant_n_out : slv_grant_n;
  always #10 mclk = ~mclk;
  ebha_arbiter dut (.*);
  ebha_master_model u_mst (.mclk(mclk), .want(want), .hold_grant_n(hold_grant_n_in),
    .hold_req_n(hold_req_n), .owns(owns));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_grant(input logic v);
    for (int i = 0; i < 20 && hold_grant_n_out !== v; i++) cyc(1);
  endtask
  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, far beyond the fewer than 150 cycles used
  initial begin
    #60000;
    error_cnt++;
    summarize;
  end
  // main sequence
  initial begin
    cyc(20);
    chk(hold_grant_n_out, 1);
    chk(bus_request_n, 1);
    chk(read_n, 1);
    resetn = 1;
    cyc(4);
    foreach (rows[i]) begin
      {ext_req, per_req, per_write, ext_write} = {rows[i].ext, rows[i].per, {2{rows[i].wr}}};
      ext_done = rows[i].ext;
      cyc_addr = rows[i].addr;
      cyc_wdata = rows[i].wd;
      cyc_cs_n = rows[i].cs;
      cyc(1);
      chk(data_port_oe, rows[i].e_oe);
      chk(address_port, rows[i].e_addr);
      chk(cs_n, rows[i].e_cs);
      chk(internal_periph_select_n, rows[i].e_sel);
      if (rows[i].e_oe) chk(data_port_out, rows[i].wd);
      chk(ale, rows[i].ext);
      {ext_req, per_req, ext_done} = 3'b000;
      cyc(1);
    end
    chk(hold_grant_n_oe, 0);
    arbitration_enable = 1;
    want = 1;
    wait_grant(0);
    chk(hold_grant_n_out, 0);
    chk(address_port_oe, 0);
    chk({seg_addr_oe, ale_oe, strobes_oe, byte_high_enable_n, write_high_byte_n}, 5'h03);
    chk(bus_request_n_oe, 1);
    chk(cs_n & {5{cs_oe}}, 5'h1f);
    ext_req = 1;
    shared_pin_direction = 1;
    shared_pin_data = 1;
    cyc(3);
    chk({ext_stall, bus_request_n, shared_pin_oe, owns, shared_pin_out}, 5'h17);
    {ext_req, shared_pin_direction, arbitration_enable} = 3'b000;
    cyc(6);
    chk(in_hold, 1);
    want = 0;
    wait_grant(1);
    cyc(1);
    chk({hold_grant_n_out, in_hold}, 2'b10);
    want = 1;
    cyc(10);
    chk({hold_grant_n_out, hold_grant_n_oe}, 2'b11);
    want = 0;
    cyc(4);
    {open_drain_cs, arbitration_enable, want} = 3'b111;
    wait_grant(0);
    cyc(2);
    chk(cs_oe, 0);
    want = 0;
    wait_grant(1);
    slave_mode_select = 1;
    cyc(3);
    chk(hold_grant_n_oe, 0);
    slv_grant_n = 0;
    cyc(6);
    chk(in_hold, 1);
    summarize;
  end
endmodule
